// >>> hw/epg_consts.vh
// Constants for the serial EEPROM power-state and write-guard block
`ifndef EPG_CONSTS_VH
`define EPG_CONSTS_VH

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define EPG_OP_WRITE_ENABLE 8'h06
`define EPG_OP_WRITE_DISABLE 8'h04
`define EPG_OP_STATUS_READ 8'h05
`define EPG_OP_STATUS_WRITE 8'h01
`define EPG_OP_ARRAY_READ 8'h03
`define EPG_OP_ARRAY_WRITE 8'h02

// ----------------------------------------------------------------------------
// Status byte layout and values
// ----------------------------------------------------------------------------
`define EPG_SR_BUSY_BIT 0
`define EPG_SR_LATCH_BIT 1
`define EPG_SR_BUSY_VALUE 8'hff

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define EPG_MCLK_PERIOD_NS 4
`define EPG_PROG_TIME_NS 5000000
`define EPG_PROG_CYCLES (`EPG_PROG_TIME_NS / `EPG_MCLK_PERIOD_NS)
`define EPG_PROG_CNT_W 24

`endif

// >>> hw/epg_write_guard.v
// Power-state, write-enable latch and programming-cycle control of a serial EEPROM
`timescale 1ns/1ps
`include "epg_consts.vh"

// Overview of operation
// - Reset release leaves device in standby with defined internal state.
// - Supply-monitor reset forces every state register to its reset value.
// - Out of reset the write enable latch is clear; writes refused.
// - Instruction decode starts only after a falling chip select.
// - Successful byte, page or status write clears the write enable latch.
// - Programming starts on chip select rise after whole bytes only.
// - Array access during programming is ignored; programming continues.
// - Unknown instruction: no action, serial output stays undriven.
// - Write enable command sets latch; write disable command clears it.
// - While programming only status read is honoured; busy reads high.
// - Status read during programming returns all ones.
module epg_write_guard #(
	parameter PROG_CYCLES = `EPG_PROG_CYCLES
) (
	MCLK,
	RESET,
	CS_N,
	SCK,
	SI,
	SO,
	SO_OE,
	BUSY,
	WRITE_ENABLE_LATCH,
	STANDBY,
	PROG_START
);
	input wire MCLK;
	input wire RESET;
	input wire CS_N;
	input wire SCK;
	input wire SI;
	output reg SO;
	output reg SO_OE;
	output reg BUSY;
	output reg WRITE_ENABLE_LATCH;
	output reg STANDBY;
	output reg PROG_START;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	reg [1:0] cs_s_r;
	reg [1:0] sck_s_r;
	reg [1:0] si_s_r;
	reg cs_d_r;
	reg sck_d_r;

	always @(posedge MCLK) begin
		if (RESET) begin
			cs_s_r <= 2'h3;
			sck_s_r <= 2'h0;
			si_s_r <= 2'h0;
			cs_d_r <= 1'b1;
			sck_d_r <= 1'b0;
		end else begin
			cs_s_r <= {cs_s_r[0], CS_N};
			sck_s_r <= {sck_s_r[0], SCK};
			si_s_r <= {si_s_r[0], SI};
			cs_d_r <= cs_s_r[1];
			sck_d_r <= sck_s_r[1];
		end
	end

	wire cs_n = cs_s_r[1];
	wire si = si_s_r[1];
	wire cs_fall = cs_d_r & ~cs_n;
	wire cs_rise = ~cs_d_r & cs_n;
	wire sck_rise = ~sck_d_r & sck_s_r[1] & ~cs_n;
	wire sck_fall = sck_d_r & ~sck_s_r[1] & ~cs_n;

	// ------------------------------------------------------------------------
	// Selection state machine
	// ------------------------------------------------------------------------
	localparam ST_STANDBY = 3'h0;
	localparam ST_OPCODE = 3'h1;
	localparam ST_STATUS = 3'h2;
	localparam ST_WRITE = 3'h3;
	localparam ST_IGNORE = 3'h4;
	localparam ST_DONE = 3'h5;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] shift_r;
	reg [7:0] shift_nxt;
	reg [2:0] bit_cnt_r;
	reg [2:0] bit_cnt_nxt;
	reg bytes_r;
	reg bytes_nxt;
	reg [7:0] sr_out_r;
	reg [7:0] sr_out_nxt;
	reg latch_nxt;
	reg so_nxt;
	reg so_oe_nxt;
	reg start_nxt;
	reg [`EPG_PROG_CNT_W-1:0] prog_cnt_r;

	wire [7:0] opcode = {shift_r[6:0], si};
	wire byte_end = sck_rise & (bit_cnt_r == 3'h7);

	always @* begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		bytes_nxt = bytes_r;
		sr_out_nxt = sr_out_r;
		latch_nxt = WRITE_ENABLE_LATCH;
		so_nxt = SO;
		so_oe_nxt = SO_OE;
		start_nxt = 1'b0;
		if (sck_rise) begin
			shift_nxt = opcode;
			bit_cnt_nxt = bit_cnt_r + 3'h1;
		end
		case (state_r)
			ST_STANDBY: begin
				if (cs_fall) begin
					state_nxt = ST_OPCODE;
					bit_cnt_nxt = 3'h0;
				end
			end
			ST_OPCODE: begin
				if (byte_end) begin
					if (opcode == `EPG_OP_STATUS_READ) begin
						state_nxt = ST_STATUS;
						if (BUSY) begin
							sr_out_nxt = `EPG_SR_BUSY_VALUE;
						end else begin
							sr_out_nxt = 8'h00;
							sr_out_nxt[`EPG_SR_LATCH_BIT] = WRITE_ENABLE_LATCH;
						end
					end else if (BUSY) begin
						state_nxt = ST_IGNORE;
					end else if (opcode == `EPG_OP_WRITE_ENABLE) begin
						latch_nxt = 1'b1;
						state_nxt = ST_DONE;
					end else if (opcode == `EPG_OP_WRITE_DISABLE) begin
						latch_nxt = 1'b0;
						state_nxt = ST_DONE;
					end else if (opcode == `EPG_OP_ARRAY_WRITE ||
						opcode == `EPG_OP_STATUS_WRITE) begin
						// Unenabled writes are dropped before any byte is taken
						state_nxt = WRITE_ENABLE_LATCH ? ST_WRITE : ST_IGNORE;
						bytes_nxt = 1'b0;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
			end
			ST_STATUS: begin
				if (sck_fall) begin
					so_oe_nxt = 1'b1;
					so_nxt = sr_out_r[7];
					sr_out_nxt = {sr_out_r[6:0], sr_out_r[7]};
				end
			end
			ST_WRITE: begin
				if (byte_end) begin
					bytes_nxt = 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (cs_rise && state_r != ST_STANDBY) begin
			state_nxt = ST_STANDBY;
			so_oe_nxt = 1'b0;
			so_nxt = 1'b0;
			// Only a frame ending on a byte boundary with data programs
			if (state_r == ST_WRITE && bytes_r && bit_cnt_r == 3'h0) begin
				start_nxt = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// State registers and programming timer
	// ------------------------------------------------------------------------
	always @(posedge MCLK) begin
		if (RESET) begin
			state_r <= ST_STANDBY;
			shift_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			bytes_r <= 1'b0;
			sr_out_r <= 8'h00;
			WRITE_ENABLE_LATCH <= 1'b0;
			SO <= 1'b0;
			SO_OE <= 1'b0;
			BUSY <= 1'b0;
			STANDBY <= 1'b1;
			PROG_START <= 1'b0;
			prog_cnt_r <= {`EPG_PROG_CNT_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			bytes_r <= bytes_nxt;
			sr_out_r <= sr_out_nxt;
			SO <= so_nxt;
			SO_OE <= so_oe_nxt;
			STANDBY <= (state_nxt == ST_STANDBY);
			PROG_START <= start_nxt;
			if (start_nxt) begin
				WRITE_ENABLE_LATCH <= 1'b0;
				BUSY <= 1'b1;
				prog_cnt_r <= PROG_CYCLES[`EPG_PROG_CNT_W-1:0] - 1'b1;
			end else begin
				WRITE_ENABLE_LATCH <= latch_nxt;
				if (BUSY) begin
					if (prog_cnt_r == {`EPG_PROG_CNT_W{1'b0}}) begin
						BUSY <= 1'b0;
					end else begin
						prog_cnt_r <= prog_cnt_r - 1'b1;
					end
				end
			end
		end
	end
endmodule

// >>> testbench/epg_sva.sv
// Port assertions for the write-guard block
`timescale 1ns/1ps
module epg_sva #(parameter PROG_CYCLES = 50) (input wire MCLK, RESET, CS_N, SCK, SI,
	SO, SO_OE, BUSY, WRITE_ENABLE_LATCH, STANDBY, PROG_START);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	int cnt;
	always @(posedge MCLK) cnt <= (RESET || !BUSY) ? 0 : cnt + 1;
	sequence s_go; PROG_START && BUSY && !WRITE_ENABLE_LATCH; endsequence
	property p_rst; $fell(RESET) |-> !WRITE_ENABLE_LATCH && STANDBY && !BUSY; endproperty
	property p_ps; PROG_START |-> $past(WRITE_ENABLE_LATCH) ##0 s_go; endproperty
	property p_bsy; $rose(BUSY) |-> s_go; endproperty
	property p_one; s_go |=> (BUSY && !PROG_START) [*8]; endproperty
	property p_len; $fell(BUSY) |-> cnt == PROG_CYCLES; endproperty
	property p_latch; $rose(WRITE_ENABLE_LATCH) |-> !BUSY && !STANDBY; endproperty
	property p_sel; $fell(STANDBY) |-> !CS_N; endproperty
	property p_ff; SO_OE && BUSY |-> SO; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_ps: assert property (p_ps) else $error("bad start");
	a_bsy: assert property (p_bsy) else $error("busy without start");
	a_one: assert property (p_one) else $error("restart in busy");
	a_len: assert property (p_len) else $error("bad busy length");
	a_latch: assert property (p_latch) else $error("latch set wrongly");
	a_sel: assert property (p_sel) else $error("left standby unselected");
	a_ff: assert property (p_ff) else $error("busy status not ones");
endmodule
bind epg_write_guard epg_sva #(.PROG_CYCLES(PROG_CYCLES)) epg_sva_i (
	.MCLK(MCLK),
	.RESET(RESET),
	.CS_N(CS_N),
	.SCK(SCK),
	.SI(SI),
	.SO(SO),
	.SO_OE(SO_OE),
	.BUSY(BUSY),
	.WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
	.STANDBY(STANDBY),
	.PROG_START(PROG_START)
);

// >>> testbench/epg_host.sv
// Serial bus host model for the link pins
`timescale 1ns/1ps
module epg_host (input wire MCLK, SO, SO_OE, output logic CS_N = 1, SCK = 0, SI = 0);
	logic [7:0] rx;
	logic oe_seen;
	task automatic hw(int n);
		repeat (n) @(negedge MCLK);
	endtask
	// SCK idles low between frames; released SI flips so no stale level survives
	task automatic frame(input logic [31:0] w, input int nb);
		oe_seen = 0;
		CS_N = 0;
		hw(4);
		for (int i = nb - 1; i >= 0; i--) begin
			SI = w[i];
			hw(4);
			SCK = 1;
			hw(4);
			// Undriven output reads as the inverse of the last bit, so a missing drive shows
			rx = {rx[6:0], SO_OE ? SO : ~rx[0]};
			oe_seen = oe_seen | SO_OE;
			SCK = 0;
		end
		hw(4);
		CS_N = 1;
		SI = ~SI;
		hw(12);
	endtask
endmodule

// >>> testbench/epg_write_guard_tb_top.sv
// Self-checking bench for the write-guard block
`timescale 1ns/1ps
module epg_write_guard_tb_top;
	logic mclk = 0;
	logic reset = 1;
	wire cs_n, sck, si, so, so_oe, busy, latch, standby, prog_start;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] seed = 57;
	logic [31:0] r;
	logic [7:0] op;
	int starts = 0;
	initial forever #2 mclk = ~mclk;
	// Programming starts seen on the pulse output, one per accepted write
	always @(negedge mclk) begin
		if (prog_start === 1'b1) begin
			starts++;
		end
	end
	epg_host epg_host_i (.MCLK(mclk), .SO(so), .SO_OE(so_oe), .CS_N(cs_n), .SCK(sck), .SI(si));
	epg_write_guard #(.PROG_CYCLES(600)) epg_write_guard_i (.MCLK(mclk), .RESET(reset),
		.CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe), .BUSY(busy),
		.WRITE_ENABLE_LATCH(latch), .STANDBY(standby), .PROG_START(prog_start));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [7:0] st(logic b, logic l);
		return b ? 8'hff : {6'h00, l, 1'b0};
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (e !== g) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmd(logic [31:0] w, int nb);
		epg_host_i.frame(w, nb);
	endtask
	task stop_test;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		reset = 0;
		repeat (3) @(negedge mclk);
		chk("latch", 0, latch);
		chk("standby", 1, standby);
		cmd(32'h02001122, 32);
		chk("busy", 0, busy);
		chk("starts", 8'h00, starts[7:0]);
		cmd(32'h06, 8);
		chk("latch", 1, latch);
		cmd(32'h0500, 16);
		chk("status", st(0, 1), epg_host_i.rx);
		chk("oe", 1, epg_host_i.oe_seen);
		cmd(32'h04, 8);
		chk("latch", 0, latch);
		for (int k = 0; k < 6; k++) begin
			r = xs();
			op = r[7:0];
			if (op inside {[8'h01:8'h06]}) op = 8'h00;
			cmd(32'h06, 8);
			cmd({16'h0000, op, 8'h00}, 16);
			chk("oe", 0, epg_host_i.oe_seen);
			chk("latch", 1, latch);
		end
		// Opcode plus half a byte must not program
		cmd(32'h020, 12);
		chk("busy", 0, busy);
		chk("latch", 1, latch);
		// Opcode, two whole bytes and half a byte must not program either
		cmd(32'h00212345, 28);
		chk("busy", 0, busy);
		chk("latch", 1, latch);
		chk("starts", 8'h00, starts[7:0]);
		for (int k = 1; k < 3; k++) begin
			r = xs();
			cmd(32'h06, 8);
			cmd(k == 1 ? {16'h0, 8'h01, r[7:0]} : {8'h02, r[23:0]}, 16 * k);
			chk("busy", 1, busy);
			chk("latch", 0, latch);
			cmd(32'h0500, 16);
			chk("status", st(1, 0), epg_host_i.rx);
			cmd(32'h06, 8);
			chk("latch", 0, latch);
			cmd({8'h02, r[23:0]}, 32);
			for (int t = 0; t < 700 && busy !== 1'b0; t++) @(negedge mclk);
			chk("busy", 0, busy);
			chk("starts", k[7:0], starts[7:0]);
			cmd(32'h0500, 16);
			chk("status", st(0, 0), epg_host_i.rx);
		end
		cmd(32'h06, 8);
		reset = 1;
		repeat (2) @(negedge mclk);
		reset = 0;
		repeat (3) @(negedge mclk);
		chk("latch", 0, latch);
		chk("standby", 1, standby);
		chk("busy", 0, busy);
		stop_test();
	end
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end
endmodule
